// ===== core/mcu_bus_if.sv
/*
  Multiplexed 8-bit microcontroller bus between host and device.
  Assumes both ends run on one clock; lanes idle high when undriven.
*/
`timescale 1ns/100ps
`include "port_fe_cfg.svh"
interface mcu_bus_if;
  logic [7:0] lo_h, lo_d, hi_h, hi_d, lo, hi;
  logic lo_h_oe, lo_d_oe, hi_h_oe, hi_d_oe;
  logic [3:0] nib;
  logic a16;
  logic address_latch_strobe;
  logic control_input_0, control_input_1, control_input_2;
  assign lo = lo_d_oe ? lo_d : (lo_h_oe ? lo_h : `LANE_IDLE);
  assign hi = hi_d_oe ? hi_d : (hi_h_oe ? hi_h : `LANE_IDLE);
  modport dev (input lo, hi, nib, address_latch_strobe, control_input_0, control_input_1,
    control_input_2, output lo_d, lo_d_oe, hi_d, hi_d_oe);
  modport host (input lo, hi, output lo_h, lo_h_oe, hi_h, hi_h_oe, nib, a16,
    address_latch_strobe, control_input_0, control_input_1, control_input_2);
endinterface

// ===== core/mcu_bus_master.sv
/*
  Host end: turns user read, write and fetch commands into bus cycles.
  Assumes the device shares SYS_CLK and answers within the strobe width.
*/
`timescale 1ns/100ps
`include "port_fe_cfg.svh"
module mcu_bus_master import port_fe_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  mcu_bus_if.host BUS,
  input bus_mode_e CFG_BUS_MODE,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_WRITE,
  input wire logic CMD_FETCH,
  input wire logic [16:0] CMD_ADDR,
  input wire logic [7:0] CMD_WDATA,
  output logic RSP_VALID,
  output logic [7:0] RSP_RDATA
);
  localparam logic [1:0] STROBE_LAST = 2'(`STROBE_CYC - 1);
  host_state_e st_q;
  logic [1:0] cnt_q;
  logic [16:0] addr_q;
  logic [7:0] wd_q, rsp_q;
  logic wr_q, fe_q, rsp_v_q, have_q, page, burst, skip, strobe, data_ph;
  logic [12:0] key_q;
  bus_mode_e mode_q;

  assign page = is_page(CFG_BUS_MODE);
  assign burst = CFG_BUS_MODE == BM_BURST8;
  // Hit only if the latched address was laid out in this same mode
  assign skip = have_q && (CFG_BUS_MODE == mode_q) && ((page && CMD_ADDR[16:8] == key_q[12:4])
    || (burst && CMD_ADDR[16:4] == key_q));

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= H_IDLE;
      cnt_q <= 2'h0;
      addr_q <= '0;
      wd_q <= 8'h00;
      wr_q <= 1'b0;
      fe_q <= 1'b0;
      have_q <= 1'b0;
      key_q <= '0;
      mode_q <= BM_BASIC;
    end else begin
      case (st_q)
        H_IDLE: if (CMD_VALID) begin
          addr_q <= CMD_ADDR;
          wd_q <= CMD_WDATA;
          wr_q <= CMD_WRITE;
          fe_q <= CMD_FETCH;
          cnt_q <= STROBE_LAST;
          st_q <= skip ? H_STROBE : H_ADDR;
        end
        H_ADDR: begin
          have_q <= 1'b1;
          key_q <= addr_q[16:4];
          mode_q <= CFG_BUS_MODE;
          st_q <= H_STROBE;
        end
        H_STROBE: begin
          if (cnt_q == 2'h0) st_q <= H_END;
          else cnt_q <= cnt_q - 2'h1;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rsp_v_q <= 1'b0;
      rsp_q <= 8'h00;
    end else begin
      rsp_v_q <= (st_q == H_STROBE) && (cnt_q == 2'h0);
      if (st_q == H_STROBE && cnt_q == 2'h0 && !wr_q) rsp_q <= page ? BUS.hi : BUS.lo;
    end
  end
  assign RSP_VALID = rsp_v_q;
  assign RSP_RDATA = rsp_q;
  assign CMD_READY = st_q == H_IDLE;

  assign strobe = st_q == H_STROBE;
  assign data_ph = strobe || st_q == H_END;
  assign BUS.address_latch_strobe = st_q == H_ADDR;
  assign BUS.nib = addr_q[3:0];
  // A16 shown while idle, ahead of the pin synchroniser delay
  assign BUS.a16 = (st_q == H_IDLE) ? CMD_ADDR[16] : addr_q[16];
  assign BUS.lo_h = (data_ph && wr_q && !page) ? wd_q : (burst ? addr_q[11:4] : addr_q[7:0]);
  assign BUS.hi_h = (data_ph && wr_q && page) ? wd_q : (burst ? {4'h0, addr_q[15:12]} : addr_q[15:8]);
  assign BUS.lo_h_oe = !(data_ph && !wr_q && !page);
  assign BUS.hi_h_oe = !(data_ph && !wr_q && page);

  always_comb begin
    BUS.control_input_0 = !(strobe && wr_q);
    BUS.control_input_1 = 1'b1;
    BUS.control_input_2 = 1'b1;
    case (CFG_BUS_MODE)
      BM_SINGLE, BM_SINGLE_PAGE: BUS.control_input_1 = !(strobe && !wr_q);
      BM_E_RW: begin
        BUS.control_input_1 = strobe;
        BUS.control_input_0 = !wr_q;
      end
      default: begin
        BUS.control_input_1 = !(strobe && !wr_q && !fe_q);
        BUS.control_input_2 = !(strobe && !wr_q && fe_q);
      end
    endcase
  end
endmodule

// ===== core/port_fe_cfg.svh
/*
  Constants for the microcontroller bus front end and its port slices.
  Assumes one 100 MHz clock and the bus modes declared in port_fe_pkg.
*/
`ifndef PORT_FE_CFG_SVH
`define PORT_FE_CFG_SVH
`define PW 8
`define NPORTS 7
`define NCAP 3
`define FIRST_CTL_PORT 4
`define ADDR_HI_PORT 6
`define IO_PAGE 9'h0FF
`define K_PIN 4'h0
`define K_DOUT 4'h1
`define K_DIR 4'h2
`define K_CTL 4'h3
`define K_CAP 4'h4
`define K_MCELL 4'h5
`define REG_RST 8'h00
`define LANE_IDLE 8'hFF
`define CLK_NS 10
`define STROBE_NS 30
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== core/port_fe_pkg.sv
/*
  Types shared by both bus ends and the port slices.
  Assumes nothing beyond the compile order.
*/
package port_fe_pkg;
  typedef enum logic [2:0] {
    BM_BASIC = 3'b000, BM_SINGLE = 3'b001, BM_SINGLE_PAGE = 3'b010,
    BM_FOURTH = 3'b011, BM_BURST8 = 3'b100, BM_E_RW = 3'b101
  } bus_mode_e;
  typedef enum logic [1:0] {CAP_PASS = 2'b00, CAP_LATCH = 2'b01, CAP_REG = 2'b10} cap_mode_e;
  typedef enum logic [1:0] {SRC_DOUT = 2'b00, SRC_ADDR = 2'b01, SRC_MCELL = 2'b10, SRC_EXTCS = 2'b11} out_src_e;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_ADDR = 2'b01, H_STROBE = 2'b10, H_END = 2'b11} host_state_e;
  function automatic logic is_page(input bus_mode_e m);
    return (m == BM_SINGLE_PAGE) || (m == BM_FOURTH);
  endfunction
  function automatic logic uses_a16(input bus_mode_e m);
    return (m == BM_SINGLE) || (m == BM_SINGLE_PAGE) || (m == BM_FOURTH);
  endfunction
endpackage

// ===== core/port_front_end.sv
/*
  Device end: bus strobe decoding, address latching and seven I/O ports.
  Assumes the host runs on SYS_CLK and stored configuration is static.
*/
`timescale 1ns/100ps
`include "port_fe_cfg.svh"
module port_front_end import port_fe_pkg::*; #(
  parameter int PW = `PW,
  parameter int NP = `NPORTS
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  mcu_bus_if.dev BUS,
  input bus_mode_e CFG_BUS_MODE,
  input wire logic [NP*PW*2-1:0] CFG_OUT_SRC,
  input wire logic [NP*PW-1:0] CFG_PT_DEF,
  input wire logic [2*`NCAP-1:0] CFG_CAP_MODE,
  input wire logic [`NCAP-1:0] CFG_CAP_USE_PT,
  input wire logic [`NCAP-1:0] CAP_PT,
  input wire logic [NP*PW-1:0] MCELL_OUT,
  input wire logic [NP*PW-1:0] EXT_CS,
  input wire logic [NP*PW-1:0] PT_OE,
  input wire logic [NP*PW-1:0] PORT_IN,
  output logic [NP*PW-1:0] PORT_OUT,
  output logic [NP*PW-1:0] PORT_OE,
  output logic [`NCAP*PW-1:0] CAP_OUT
);
  logic rd_act, wr_act, page, a16, hit;
  logic [7:0] lat_lo_q, lat_hi_q, rd_data_q, wd_q, data_lane;
  logic [15:0] addr;
  logic [3:0] kind, port, wkind_q, wport_q;
  logic wr_q, whit_q, wr_pulse;
  logic [PW-1:0] rb [NP];
  logic [PW-1:0] lvl [NP];

  // Strobe assignment per bus configuration
  always_comb begin
    rd_act = 1'b0;
    wr_act = !BUS.control_input_0;
    case (CFG_BUS_MODE)
      BM_BASIC, BM_BURST8: rd_act = !BUS.control_input_1 || !BUS.control_input_2;
      BM_SINGLE, BM_SINGLE_PAGE: rd_act = !BUS.control_input_1;
      BM_FOURTH: rd_act = !BUS.control_input_1 || !BUS.control_input_2;
      BM_E_RW: begin
        rd_act = BUS.control_input_1 && BUS.control_input_0;
        wr_act = BUS.control_input_1 && !BUS.control_input_0;
      end
      default: rd_act = 1'b0;
    endcase
  end

  // Address latch
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lat_lo_q <= 8'h00;
      lat_hi_q <= 8'h00;
    end else if (BUS.address_latch_strobe) begin
      lat_lo_q <= BUS.lo;
      lat_hi_q <= BUS.hi;
    end
  end

  // Address assembly
  always_comb begin
    page = is_page(CFG_BUS_MODE);
    if (page) addr = {lat_hi_q, BUS.lo};
    else if (CFG_BUS_MODE == BM_BURST8) addr = {lat_hi_q[3:0], lat_lo_q, BUS.nib};
    else addr = {lat_hi_q, lat_lo_q};
    a16 = uses_a16(CFG_BUS_MODE) && lvl[0][0];
    kind = addr[7:4];
    port = addr[3:0];
    hit = ({a16, addr[15:8]} == `IO_PAGE) && (port < 4'(NP));
    data_lane = page ? BUS.hi : BUS.lo;
  end

  // Read path
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_data_q <= 8'h00;
    end else if (port < 4'(NP)) begin
      rd_data_q <= rb[port[2:0]];
    end else begin
      rd_data_q <= 8'h00;
    end
  end
  assign BUS.lo_d = rd_data_q;
  assign BUS.hi_d = rd_data_q;
  assign BUS.lo_d_oe = hit && rd_act && !page;
  assign BUS.hi_d_oe = hit && rd_act && page;

  // Write path: commit at strobe end
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_q <= 1'b0;
      wd_q <= 8'h00;
      wkind_q <= 4'h0;
      wport_q <= 4'h0;
      whit_q <= 1'b0;
    end else begin
      wr_q <= wr_act;
      if (wr_act) begin
        wd_q <= data_lane;
        wkind_q <= kind;
        wport_q <= port;
        whit_q <= hit;
      end
    end
  end
  assign wr_pulse = wr_q && !wr_act && whit_q;

  for (genvar p = 0; p < NP; p++) begin : g_port
    cap_mode_e cmode;
    logic cclk;
    logic [PW-1:0] cout;
    if (p < `NCAP) begin : g_cap
      assign cmode = cap_mode_e'(CFG_CAP_MODE[2*p +: 2]);
      assign cclk = CFG_CAP_USE_PT[p] ? CAP_PT[p] : BUS.address_latch_strobe;
      assign CAP_OUT[p*PW +: PW] = cout;
    end else begin : g_nocap
      assign cmode = CAP_PASS;
      assign cclk = 1'b0;
    end
    port_slice #(
      .W(PW),
      .HAS_CTL(p >= `FIRST_CTL_PORT)
    ) u_slice (
      .clk(SYS_CLK),
      .rst_n(ARST_N),
      .wr_en(wr_pulse && (wport_q == 4'(p))),
      .kind(wr_pulse ? wkind_q : kind),
      .wdata(wd_q),
      .rdata(rb[p]),
      .addr_out((p == `ADDR_HI_PORT) ? addr[15:8] : addr[7:0]),
      .mcell(MCELL_OUT[p*PW +: PW]),
      .ext_cs(EXT_CS[p*PW +: PW]),
      .pt_oe(PT_OE[p*PW +: PW]),
      .pt_def(CFG_PT_DEF[p*PW +: PW]),
      .out_src(CFG_OUT_SRC[p*PW*2 +: PW*2]),
      .cap_mode(cmode),
      .cap_clk(cclk),
      .pin_in(PORT_IN[p*PW +: PW]),
      .pin_lvl(lvl[p]),
      .pin_out(PORT_OUT[p*PW +: PW]),
      .pin_oe(PORT_OE[p*PW +: PW]),
      .cap_out(cout)
    );
  end
endmodule

// ===== core/port_slice.sv
/*
  One 8-pin I/O port: registers, output mux, enable, capture, readback.
  Assumes pin inputs are asynchronous and writes arrive as one-cycle pulses.
*/
`timescale 1ns/100ps
`include "port_fe_cfg.svh"
module port_slice import port_fe_pkg::*; #(
  parameter int W = `PW,
  parameter bit HAS_CTL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [3:0] kind,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rdata,
  input wire logic [W-1:0] addr_out,
  input wire logic [W-1:0] mcell,
  input wire logic [W-1:0] ext_cs,
  input wire logic [W-1:0] pt_oe,
  input wire logic [W-1:0] pt_def,
  input wire logic [2*W-1:0] out_src,
  input cap_mode_e cap_mode,
  input wire logic cap_clk,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_lvl,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] cap_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, dout_q, dir_q, ctl_q, out_q, cap_q;
  logic cap_clk_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) lvl_q[i] <= s3_q[i];
      end
    end
  end
  assign pin_lvl = lvl_q;
  // Host-written port registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= `REG_RST;
      dir_q <= `REG_RST;
      ctl_q <= `REG_RST;
    end else if (wr_en) begin
      if (kind == `K_DOUT) dout_q <= wdata;
      else if (kind == `K_DIR) dir_q <= wdata;
      else if (kind == `K_CTL && HAS_CTL) ctl_q <= wdata;
    end
  end
  // One source per pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (ctl_q[i]) out_q[i] <= addr_out[i];
        else begin
          case (out_src_e'(out_src[2*i +: 2]))
            SRC_ADDR: out_q[i] <= addr_out[i];
            SRC_MCELL: out_q[i] <= mcell[i];
            SRC_EXTCS: out_q[i] <= ext_cs[i];
            default: out_q[i] <= dout_q[i];
          endcase
        end
      end
    end
  end
  assign pin_out = out_q;
  assign pin_oe = (pt_def & pt_oe) | dir_q;
  // Capture cell
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_q <= '0;
      cap_clk_q <= 1'b0;
    end else begin
      cap_clk_q <= cap_clk;
      if (cap_mode == CAP_LATCH && cap_clk) cap_q <= lvl_q;
      else if (cap_mode == CAP_REG && cap_clk && !cap_clk_q) cap_q <= lvl_q;
    end
  end
  assign cap_out = (cap_mode == CAP_PASS) ? lvl_q : cap_q;
  always_comb begin
    if (kind == `K_DOUT) rdata = dout_q;
    else if (kind == `K_DIR) rdata = dir_q;
    else if (kind == `K_CTL) rdata = ctl_q;
    else if (kind == `K_CAP) rdata = cap_out;
    else if (kind == `K_MCELL) rdata = mcell;
    else rdata = lvl_q;
  end
endmodule

// ===== dv/port_fe_chk.sv
/*
  Checker on the bus between host end and device end.
  Assumes the bus signals are wired in by name beside the interface.
*/
`timescale 1ns/100ps
module port_fe_chk (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] lo,
  input wire logic lo_d_oe,
  input wire logic lo_h_oe,
  input wire logic hi_d_oe,
  input wire logic address_latch_strobe,
  input wire logic control_input_0,
  input wire logic control_input_1,
  input wire logic control_input_2
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);
  // Strobe low three cycles, then released
  sequence fetch_low;
    !control_input_2 [*3] ##1 control_input_2;
  endsequence
  sequence write_low;
    !control_input_0 [*3] ##1 control_input_0;
  endsequence
  a_one_lane: assert property (!(lo_d_oe && hi_d_oe))
    else $error("both data lanes driven");
  a_drive_strobe: assert property ((lo_d_oe || hi_d_oe) |->
    !address_latch_strobe && (!control_input_1 || !control_input_2 || control_input_0))
    else $error("data driven outside a read");
  a_fetch_width: assert property ($fell(control_input_2) |-> fetch_low)
    else $error("fetch strobe width wrong");
  a_write_width: assert property ($fell(control_input_0) |-> write_low)
    else $error("write strobe width wrong");
  a_ale_pulse: assert property ($rose(address_latch_strobe) |=> !address_latch_strobe)
    else $error("latch strobe too long");
  a_ale_quiet: assert property (address_latch_strobe |-> control_input_0 && control_input_2)
    else $error("latch strobe during a strobe");
  a_fetch_release: assert property ($rose(control_input_2) |-> !lo_d_oe && !hi_d_oe)
    else $error("data held after fetch");
  a_lane_idle: assert property (!lo_d_oe && !lo_h_oe |-> lo == 8'hFF)
    else $error("released lane not idle");
endmodule

// ===== dv/tb.sv
/*
  Top bench: host end and device end joined by the bus interface.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/100ps
module tb;
  import port_fe_pkg::*;
  logic SYS_CLK = 1'b0;
  logic ARST_N = 1'b0;
  bus_mode_e mode = BM_BASIC;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_fetch = 1'b0;
  logic [16:0] cmd_addr = 17'h00000;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  logic [55:0] pin_q = 56'h0;
  logic [55:0] pt_def = 56'h0000000F000000;
  logic [55:0] pt_oe = 56'hFFFFFFFFFFFFFF;
  logic [111:0] out_src = 112'h0;
  logic [55:0] port_out;
  logic [55:0] port_oe;
  logic [23:0] cap_out;
  int bad_count = 0;
  int num_checks = 0;
  bus_mode_e modes [6] = '{BM_BASIC, BM_SINGLE, BM_SINGLE_PAGE, BM_FOURTH, BM_BURST8, BM_E_RW};
  mcu_bus_if i_mcu_bus_if ();
  mcu_bus_master i_mcu_bus_master (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .BUS(i_mcu_bus_if), .CFG_BUS_MODE(mode),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write), .CMD_FETCH(cmd_fetch),
    .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata));
  port_front_end i_port_front_end (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .BUS(i_mcu_bus_if), .CFG_BUS_MODE(mode),
    .CFG_OUT_SRC(out_src), .CFG_PT_DEF(pt_def), .CFG_CAP_MODE(6'h08), .CFG_CAP_USE_PT(3'h0), .CAP_PT(3'h0),
    .MCELL_OUT(56'h66554433221100), .EXT_CS(56'h0), .PT_OE(pt_oe), .PORT_IN({pin_q[55:1], i_mcu_bus_if.a16}),
    .PORT_OUT(port_out), .PORT_OE(port_oe), .CAP_OUT(cap_out));
  port_fe_chk u_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .lo(i_mcu_bus_if.lo), .lo_d_oe(i_mcu_bus_if.lo_d_oe),
    .lo_h_oe(i_mcu_bus_if.lo_h_oe), .hi_d_oe(i_mcu_bus_if.hi_d_oe),
    .address_latch_strobe(i_mcu_bus_if.address_latch_strobe), .control_input_0(i_mcu_bus_if.control_input_0),
    .control_input_1(i_mcu_bus_if.control_input_1), .control_input_2(i_mcu_bus_if.control_input_2));
  function automatic logic [16:0] ad(input logic [3:0] k, input logic [3:0] p);
    return {9'h0FF, k, p};
  endfunction
  task automatic chk(input string nm, input logic [55:0] exp, input logic [55:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One bus command, held until taken, then wait for the response
  task automatic acc(input logic wr, input logic fe, input logic [16:0] a, input logic [7:0] d,
    input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_fetch <= fe;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(negedge SYS_CLK);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge SYS_CLK);
      n++;
    end
    @(posedge SYS_CLK);
    cmd_valid <= 1'b0;
    @(negedge SYS_CLK);
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(negedge SYS_CLK);
      n++;
    end
    chk("response seen", 56'h1, {55'h0, rsp_valid});
    if (!wr) chk("read data", {48'h0, exp}, {48'h0, rsp_rdata});
  endtask
  initial begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge SYS_CLK);
    chk("reset enables", 56'h0000000F000000, port_oe);
    chk("reset outputs", 56'h0, port_out);
    ARST_N <= 1'b1;
    for (int p = 0; p < 7; p++) begin
      acc(1'b1, 1'b0, ad(4'h1, p[3:0]), 8'h10 + p[7:0], 8'h00);
      acc(1'b1, 1'b0, ad(4'h2, p[3:0]), 8'hFF, 8'h00);
      acc(1'b0, 1'b0, ad(4'h1, p[3:0]), 8'h00, 8'h10 + p[7:0]);
    end
    repeat (3) @(posedge SYS_CLK);
    chk("port outputs", 56'h16151413121110, port_out);
    chk("port enables", 56'hFFFFFFFFFFFFFF, port_oe);
    acc(1'b0, 1'b1, ad(4'h2, 4'h5), 8'h00, 8'hFF);
    acc(1'b0, 1'b0, ad(4'h5, 4'h3), 8'h00, 8'h33);
    acc(1'b1, 1'b0, ad(4'h3, 4'h0), 8'hFF, 8'h00);
    acc(1'b0, 1'b0, ad(4'h3, 4'h0), 8'h00, 8'h00);
    acc(1'b1, 1'b0, ad(4'h3, 4'h4), 8'hFF, 8'h00);
    acc(1'b0, 1'b0, ad(4'h3, 4'h4), 8'h00, 8'hFF);
    acc(1'b0, 1'b0, ad(4'h2, 4'h0), 8'h00, 8'hFF);
    repeat (4) @(posedge SYS_CLK);
    chk("address out", 56'h20, {48'h0, port_out[39:32]});
    acc(1'b1, 1'b0, ad(4'h3, 4'h4), 8'h00, 8'h00);
    acc(1'b0, 1'b0, 17'h0FE20, 8'h00, 8'hFF);
    acc(1'b0, 1'b0, ad(4'h1, 4'h7), 8'h00, 8'hFF);
    @(posedge SYS_CLK);
    pin_q[23:8] <= 16'h3C5A;
    repeat (6) @(posedge SYS_CLK);
    acc(1'b0, 1'b0, ad(4'h0, 4'h2), 8'h00, 8'h3C);
    @(posedge SYS_CLK);
    pin_q[15:8] <= 8'h77;
    repeat (6) @(posedge SYS_CLK);
    chk("capture held", 56'h5A, {48'h0, cap_out[15:8]});
    acc(1'b0, 1'b0, ad(4'h4, 4'h1), 8'h00, 8'h77);
    acc(1'b1, 1'b0, ad(4'h2, 4'h3), 8'h00, 8'h00);
    repeat (2) @(posedge SYS_CLK);
    chk("term enable", 56'h0F, {48'h0, port_oe[31:24]});
    pt_oe <= 56'h0;
    repeat (2) @(posedge SYS_CLK);
    chk("term off", 56'h00, {48'h0, port_oe[31:24]});
    out_src[9:8] <= 2'b10;
    repeat (2) @(posedge SYS_CLK);
    chk("mux source", 56'h00, {48'h0, port_out[7:0]});
    for (int i = 0; i < 6; i++) begin
      @(posedge SYS_CLK);
      mode <= modes[i];
      acc(1'b0, modes[i] == BM_SINGLE || modes[i] == BM_SINGLE_PAGE, ad(4'h1, 4'h1), 8'h00, 8'h11);
      acc(1'b0, modes[i] == BM_SINGLE || modes[i] == BM_SINGLE_PAGE, ad(4'h1, 4'h2), 8'h00, 8'h12);
    end
    @(posedge SYS_CLK);
    mode <= BM_FOURTH;
    acc(1'b0, 1'b1, ad(4'h1, 4'h1), 8'h00, 8'h11);
    acc(1'b0, 1'b0, 17'h1FF11, 8'h00, 8'hFF);
    give_verdict();
  end
endmodule
